//--- design/ddrbs_pkg.sv
package ddrbs_pkg;

   // Geometry and clocking
   localparam int NBANK = 8;
   localparam int BA_W = 3;
   localparam int MCLK_NS = 4;
   localparam int CK_HALF = 2; // mclk cycles per link clock half period
   localparam int CK_NS = MCLK_NS * 2 * CK_HALF;

   // Timing figures as printed units (ns or link clocks)
   localparam int T_RP_NS = 15;
   localparam int T_RCD_NS = 15;
   localparam int T_RFC_NS = 128;
   localparam int T_MRD_CK = 2;
   localparam int BL = 4;

   // Least times rounded up to whole link clocks
   localparam logic [7:0] RP_CNT = 8'((T_RP_NS + CK_NS - 1) / CK_NS);
   localparam logic [7:0] RCD_CNT = 8'((T_RCD_NS + CK_NS - 1) / CK_NS);
   localparam logic [7:0] RFC_CNT = 8'((T_RFC_NS + CK_NS - 1) / CK_NS);
   localparam logic [7:0] MRD_CNT = 8'(T_MRD_CK);
   localparam logic [7:0] BURST_CNT = 8'(BL / 2);

   typedef enum logic [3:0]
   {
      CMD_DESEL, CMD_NOP, CMD_ACT, CMD_RD, CMD_WR,
      CMD_PRE, CMD_REF, CMD_LM, CMD_RSVD
   } ddrbs_cmd_t;

   typedef enum logic [2:0]
   {
      BS_IDLE, BS_ACTG, BS_ACTIVE, BS_READ,
      BS_WRITE, BS_RDAP, BS_WRAP, BS_PRE
   } ddrbs_bst_t;

   typedef enum logic [1:0] {DW_NONE, DW_REF, DW_LM, DW_PALL} ddrbs_dw_t;

   typedef struct packed
   {
      ddrbs_bst_t st;
      logic [7:0] cnt;
   } ddrbs_bank_t;

   typedef struct packed
   {
      ddrbs_dw_t st;
      logic [7:0] cnt;
   } ddrbs_dev_t;

   typedef ddrbs_bank_t ddrbs_banks_t [NBANK];

   // Pin pattern {cs_n, ras_n, cas_n, we_n} to command
   function automatic ddrbs_cmd_t ddrbs_decode(input logic [3:0] p);
      ddrbs_cmd_t c;
      c = CMD_RSVD;
      if (p[3])
         c = CMD_DESEL;
      else
      begin
         case (p[2:0])
            3'h7: c = CMD_NOP;
            3'h3: c = CMD_ACT;
            3'h5: c = CMD_RD;
            3'h4: c = CMD_WR;
            3'h2: c = CMD_PRE;
            3'h1: c = CMD_REF;
            3'h0: c = CMD_LM;
            default: c = CMD_RSVD;
         endcase
      end
      return c;
   endfunction

   function automatic logic [3:0] ddrbs_encode(input ddrbs_cmd_t c);
      logic [3:0] p;
      case (c)
         CMD_NOP: p = 4'h7;
         CMD_ACT: p = 4'h3;
         CMD_RD: p = 4'h5;
         CMD_WR: p = 4'h4;
         CMD_PRE: p = 4'h2;
         CMD_REF: p = 4'h1;
         CMD_LM: p = 4'h0;
         default: p = 4'hf;
      endcase
      return p;
   endfunction

   // Whether a command may be registered given every bank's state
   function automatic logic ddrbs_legal(input ddrbs_banks_t bk,
      input ddrbs_dw_t dw, input ddrbs_cmd_t c, input logic [2:0] ba,
      input logic a10);
      logic all_idle;
      logic pre_ok;
      logic rd_other;
      logic open_b;
      logic free;
      logic ok;
      all_idle = 1'b1;
      pre_ok = 1'b1;
      rd_other = 1'b0;
      for (int i = 0; i < NBANK; i++)
      begin
         if (bk[i].st != BS_IDLE)
            all_idle = 1'b0;
         if (!(bk[i].st inside {BS_IDLE, BS_ACTIVE, BS_READ, BS_WRITE}))
            pre_ok = 1'b0;
         if (3'(i) != ba && (bk[i].st == BS_READ ||
            (bk[i].st == BS_RDAP && bk[i].cnt > RP_CNT)))
            rd_other = 1'b1;
      end
      open_b = bk[ba].st inside {BS_ACTIVE, BS_READ, BS_WRITE};
      free = (dw == DW_NONE);
      case (c)
         CMD_DESEL, CMD_NOP: ok = 1'b1;
         CMD_ACT: ok = free && bk[ba].st == BS_IDLE;
         CMD_RD: ok = free && open_b;
         CMD_WR: ok = free && open_b && !rd_other;
         CMD_PRE: ok = free && (a10 ? pre_ok : open_b);
         CMD_REF, CMD_LM: ok = free && all_idle;
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction

   // One link clock of a bank; c is a command already accepted
   function automatic ddrbs_bank_t ddrbs_step(input ddrbs_bank_t b,
      input ddrbs_cmd_t c, input logic hit, input logic a10);
      ddrbs_bank_t n;
      n = b;
      if (c == CMD_PRE && (hit || a10))
      begin
         n.st = BS_PRE;
         n.cnt = RP_CNT;
      end
      else if (hit && c == CMD_ACT)
      begin
         n.st = BS_ACTG;
         n.cnt = RCD_CNT;
      end
      else if (hit && (c == CMD_RD || c == CMD_WR))
      begin
         if (c == CMD_RD)
            n.st = a10 ? BS_RDAP : BS_READ;
         else
            n.st = a10 ? BS_WRAP : BS_WRITE;
         n.cnt = a10 ? BURST_CNT + RP_CNT : BURST_CNT;
      end
      else if (b.cnt > 8'h01)
         n.cnt = b.cnt - 8'h01;
      else if (b.cnt == 8'h01)
      begin
         n.cnt = 8'h00;
         case (b.st)
            BS_ACTG, BS_READ, BS_WRITE: n.st = BS_ACTIVE;
            BS_RDAP, BS_WRAP, BS_PRE: n.st = BS_IDLE;
            default: n.st = b.st;
         endcase
      end
      return n;
   endfunction

   // One link clock of the device-wide busy state
   function automatic ddrbs_dev_t ddrbs_dw_step(input ddrbs_dev_t d,
      input ddrbs_cmd_t c, input logic a10);
      ddrbs_dev_t n;
      n = d;
      if (c == CMD_REF)
      begin
         n.st = DW_REF;
         n.cnt = RFC_CNT;
      end
      else if (c == CMD_LM)
      begin
         n.st = DW_LM;
         n.cnt = MRD_CNT;
      end
      else if (c == CMD_PRE && a10)
      begin
         n.st = DW_PALL;
         n.cnt = RP_CNT;
      end
      else if (d.cnt > 8'h01)
         n.cnt = d.cnt - 8'h01;
      else
      begin
         n.cnt = 8'h00;
         n.st = DW_NONE;
      end
      return n;
   endfunction

endpackage

//--- design/ddrbs_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ddrbs_if;
   logic ck;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic a10;
   logic [2:0] ba;
   modport ctrl (output ck, cke, cs_n, ras_n, cas_n, we_n, a10, ba);
   modport dev (input ck, cke, cs_n, ras_n, cas_n, we_n, a10, ba);
endinterface
`default_nettype wire

//--- design/ddrbs_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module ddrbs_ctrl
   import ddrbs_pkg::*;
(
   ddrbs_if.ctrl link,
   input wire logic mclk,
   input wire logic resetn,
   input wire logic req_valid,
   input wire ddrbs_cmd_t req_cmd,
   input wire logic [2:0] req_ba,
   input wire logic req_a10,
   output logic req_ack
);

   logic [7:0] div_q;
   logic ck_q;
   logic cke_q;
   logic cke_seen_q;
   logic link_up_q;
   ddrbs_cmd_t cmd_q;
   logic [3:0] pin_q;
   logic [2:0] ba_q;
   logic a10_q;
   logic ack_q;
   ddrbs_banks_t bank_q;
   ddrbs_banks_t bank_d;
   ddrbs_dev_t dev_q;
   ddrbs_dev_t dev_d;
   ddrbs_cmd_t exec_cmd;
   logic wrap;
   logic rise_tick;
   logic fall_tick;
   logic cke_ok;
   logic take;

   // Link clock divider; pins change at the falling edge
   assign wrap = (div_q == 8'(CK_HALF - 1));
   assign rise_tick = wrap && !ck_q;
   assign fall_tick = wrap && ck_q;

   // Mirror of what the device sees at the coming rising edge
   assign cke_ok = cke_q && cke_seen_q;
   assign exec_cmd = cke_ok ? cmd_q : CMD_NOP;
   assign dev_d = ddrbs_dw_step(dev_q, exec_cmd, a10_q);
   for (genvar i = 0; i < NBANK; i++)
   begin : g_shadow
      assign bank_d[i] = ddrbs_step(bank_q[i], exec_cmd,
         ba_q == 3'(i), a10_q);
   end

   // Only a legal request is sent, else a NOP
   assign take = fall_tick && req_valid && cke_ok && link_up_q &&
      ddrbs_legal(bank_q, dev_q.st, req_cmd, req_ba,
      req_a10);

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         div_q <= 8'h00;
         ck_q <= 1'b0;
      end
      else
      begin
         div_q <= wrap ? 8'h00 : div_q + 8'h01;
         ck_q <= wrap ? !ck_q : ck_q;
      end
   end

   // Shadow bank state advances once per link clock
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int i = 0; i < NBANK; i++)
            bank_q[i] <= '{BS_IDLE, 8'h00};
         dev_q <= '{DW_NONE, 8'h00};
         cke_seen_q <= 1'b0;
         link_up_q <= 1'b0;
      end
      else if (rise_tick)
      begin
         bank_q <= bank_d;
         dev_q <= dev_d;
         cke_seen_q <= cke_q;
         link_up_q <= cke_seen_q; // Device leaves reset two rises late
      end
   end

   // Command launch half a link clock before it is registered
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         cke_q <= 1'b0;
         cmd_q <= CMD_NOP;
         pin_q <= 4'h7;
         ba_q <= 3'h0;
         a10_q <= 1'b0;
         ack_q <= 1'b0;
      end
      else
      begin
         ack_q <= take;
         if (fall_tick)
         begin
            cke_q <= 1'b1;
            cmd_q <= take ? req_cmd : CMD_NOP;
            pin_q <= ddrbs_encode(take ? req_cmd : CMD_NOP);
            ba_q <= take ? req_ba : 3'h0;
            a10_q <= take ? req_a10 : 1'b0;
         end
      end
   end

   assign link.ck = ck_q;
   assign link.cke = cke_q;
   assign {link.cs_n, link.ras_n, link.cas_n, link.we_n} = pin_q;
   assign link.ba = ba_q;
   assign link.a10 = a10_q;
   assign req_ack = ack_q;

endmodule
`default_nettype wire

//--- design/ddrbs_dev.sv
`timescale 1ns/1ns
`default_nettype none
module ddrbs_dev
   import ddrbs_pkg::*;
(
   ddrbs_if.dev link,
   input wire logic mclk,
   input wire logic resetn,
   output logic [NBANK-1:0] bank_idle,
   output logic [NBANK-1:0] bank_open,
   output logic all_idle,
   output logic dev_busy,
   output logic cmd_error
);

   // Link clock domain
   logic rst_s1_q;
   logic rst_s2_q;
   logic ck_rstn;
   logic cke_prev_q;
   ddrbs_banks_t bank_q;
   ddrbs_banks_t bank_d;
   ddrbs_dev_t dev_q;
   ddrbs_dev_t dev_d;
   ddrbs_cmd_t raw_cmd;
   ddrbs_cmd_t cmd_in;
   ddrbs_cmd_t exec_cmd;
   logic cke_ok;
   logic legal;
   logic err_tgl_q;
   logic [NBANK-1:0] idle_ck_q;
   logic [NBANK-1:0] open_ck_q;
   logic busy_ck_q;
   logic [NBANK-1:0] idle_w;
   logic [NBANK-1:0] open_w;

   // Core clock domain
   logic [NBANK-1:0] idle_s1_q;
   logic [NBANK-1:0] idle_s2_q;
   logic [NBANK-1:0] open_s1_q;
   logic [NBANK-1:0] open_s2_q;
   logic busy_s1_q;
   logic busy_s2_q;
   logic err_s1_q;
   logic err_s2_q;
   logic err_s3_q;
   logic all_idle_q;
   logic err_q;

   // Reset released in step with the link clock
   always_ff @(posedge link.ck or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   assign ck_rstn = rst_s2_q;

   // Command decode; deselect and NOP leave work running
   assign raw_cmd = ddrbs_decode({link.cs_n, link.ras_n,
      link.cas_n, link.we_n});

   // Without clock enable on two edges nothing is registered
   assign cke_ok = link.cke && cke_prev_q;
   assign cmd_in = cke_ok ? raw_cmd : CMD_DESEL;

   // Same-bank and cross-bank legality of the incoming command
   assign legal = ddrbs_legal(bank_q, dev_q.st, cmd_in, link.ba,
      link.a10);

   // An illegal command is dropped and reported, never executed
   assign exec_cmd = legal ? cmd_in : CMD_NOP;

   // Device-wide refresh, load mode and precharge-all timers
   assign dev_d = ddrbs_dw_step(dev_q, exec_cmd,
      link.a10);

   // Per-bank timers; A10 picks the auto precharge variant
   for (genvar i = 0; i < NBANK; i++)
   begin : g_bank
      assign bank_d[i] = ddrbs_step(bank_q[i], exec_cmd,
         link.ba == 3'(i),
         link.a10);
      assign idle_w[i] = (bank_d[i].st == BS_IDLE);
      assign open_w[i] = (bank_d[i].st == BS_ACTIVE);
   end

   // Bank and device state registers
   always_ff @(posedge link.ck or negedge ck_rstn)
   begin
      if (!ck_rstn)
      begin
         for (int i = 0; i < NBANK; i++)
            bank_q[i] <= '{BS_IDLE, 8'h00};
         dev_q <= '{DW_NONE, 8'h00};
         cke_prev_q <= 1'b0;
      end
      else
      begin
         bank_q <= bank_d;
         dev_q <= dev_d;
         cke_prev_q <= link.cke;
      end
   end

   // Status launched from flops so the crossing sees no glitches
   always_ff @(posedge link.ck or negedge ck_rstn)
   begin
      if (!ck_rstn)
      begin
         idle_ck_q <= '1;
         open_ck_q <= '0;
         busy_ck_q <= 1'b0;
         err_tgl_q <= 1'b0;
      end
      else
      begin
         idle_ck_q <= idle_w;
         open_ck_q <= open_w;
         busy_ck_q <= (dev_d.st != DW_NONE);
         err_tgl_q <= err_tgl_q ^ !legal;
      end
   end

   // Level crossing; each flag is independent so bits may skew
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         idle_s1_q <= '1;
         idle_s2_q <= '1;
         open_s1_q <= '0;
         open_s2_q <= '0;
         busy_s1_q <= 1'b0;
         busy_s2_q <= 1'b0;
      end
      else
      begin
         idle_s1_q <= idle_ck_q;
         idle_s2_q <= idle_s1_q;
         open_s1_q <= open_ck_q;
         open_s2_q <= open_s1_q;
         busy_s1_q <= busy_ck_q;
         busy_s2_q <= busy_s1_q;
      end
   end

   // Error event crosses as a toggle, rebuilt as one pulse
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         err_s1_q <= 1'b0;
         err_s2_q <= 1'b0;
         err_s3_q <= 1'b0;
         err_q <= 1'b0;
         all_idle_q <= 1'b1;
      end
      else
      begin
         err_s1_q <= err_tgl_q;
         err_s2_q <= err_s1_q;
         err_s3_q <= err_s2_q;
         err_q <= err_s2_q ^ err_s3_q;
         all_idle_q <= &idle_s2_q;
      end
   end

   assign bank_idle = idle_s2_q;
   assign bank_open = open_s2_q;
   assign all_idle = all_idle_q;
   assign dev_busy = busy_s2_q;
   assign cmd_error = err_q;

endmodule
`default_nettype wire

//--- verification/ddrbs_chk.sv
`timescale 1ns/1ns
`default_nettype none
module ddrbs_chk
   import ddrbs_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic ck,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic a10,
   input wire logic [2:0] ba
);
   // Own pin decode, kept apart from the design's helpers
   wire logic [3:0] pins = {cs_n, ras_n, cas_n, we_n};
   wire logic quiet = cs_n || (pins[2:0] == 3'h7);
   wire logic is_ref = (pins == 4'h1);
   wire logic is_lm = (pins == 4'h0);
   wire logic is_act = (pins == 4'h3);
   wire logic is_rd = (pins == 4'h5);
   wire logic is_wr = (pins == 4'h4);

   // Steps of the busy phases, as seen at each link rise
   sequence s_ref_issued;
      is_ref && cke;
   endsequence
   sequence s_quiet8;
      quiet [*8];
   endsequence
   sequence s_lm_issued;
      is_lm && cke;
   endsequence

   property p_ref_quiet;
      @(posedge ck) disable iff (!resetn) s_ref_issued |=> s_quiet8;
   endproperty
   a_ref_quiet: assert property (p_ref_quiet)
      else $error("pins not quiet during refresh");

   property p_lm_quiet;
      @(posedge ck) disable iff (!resetn) s_lm_issued |=> quiet [*2];
   endproperty
   a_lm_quiet: assert property (p_lm_quiet)
      else $error("pins not quiet after load mode");

   // A write to another bank must wait out the read burst
   a_rd_then_wr: assert property (@(posedge ck) disable iff (!resetn)
      is_rd |=> !(is_wr && (ba != $past(ba))))
      else $error("write to other bank during read burst");

   // Bank just opened, so refresh or load mode cannot follow
   a_act_no_ref: assert property (@(posedge ck) disable iff (!resetn)
      is_act |=> !(is_ref || is_lm))
      else $error("refresh or load mode with a bank open");

   a_no_reserved: assert property (@(posedge ck) disable iff (!resetn)
      pins != 4'h6)
      else $error("reserved pin pattern sent");

   a_cke_before: assert property (@(posedge ck) disable iff (!resetn)
      !quiet |-> (cke && $past(cke)))
      else $error("command sent without clock enable held");

   a_cke_stays: assert property (@(posedge mclk) disable iff (!resetn)
      $past(cke) |-> cke)
      else $error("clock enable dropped");

   // Pins move only with the link clock's fall, so a rise sees them settled
   a_pins_at_fall: assert property (@(posedge mclk) disable iff (!resetn)
      !$stable(pins) |-> $fell(ck))
      else $error("command pins changed away from clock fall");
endmodule
`default_nettype wire

//--- verification/test_ddrbs_bank_command_state_rules.sv
`timescale 1ns/1ns
`default_nettype none
module test_ddr2_bank_command_state_rules
   import ddrbs_pkg::*;
;
   logic mclk, resetn, req_valid, req_a10, req_ack, a_idle, busy, err, err2;
   ddrbs_cmd_t req_cmd;
   logic [2:0] req_ba;
   logic [7:0] b_idle, b_open, b_idle2;
   int n_fail, cmp_count, n_err1, n_err2, cyc, t0;
   localparam int CKM = 2 * CK_HALF; // mclk cycles per link clock
   ddrbs_if lk();
   ddrbs_if lk2();

   ddrbs_ctrl ddrbs_ctrl_inst (.link(lk), .mclk(mclk), .resetn(resetn),
      .req_valid(req_valid), .req_cmd(req_cmd), .req_ba(req_ba),
      .req_a10(req_a10), .req_ack(req_ack));
   ddrbs_dev ddrbs_dev_inst (.link(lk), .mclk(mclk), .resetn(resetn),
      .bank_idle(b_idle), .bank_open(b_open), .all_idle(a_idle),
      .dev_busy(busy), .cmd_error(err));
   // Second device, driven by the bench to break the rules on purpose
   ddrbs_dev ddrbs_dev_inst_b (.link(lk2), .mclk(mclk), .resetn(resetn),
      .bank_idle(b_idle2), .bank_open(), .all_idle(), .dev_busy(),
      .cmd_error(err2));
   ddrbs_chk ddrbs_chk_inst (.mclk(mclk), .resetn(resetn), .ck(lk.ck),
      .cke(lk.cke), .cs_n(lk.cs_n), .ras_n(lk.ras_n), .cas_n(lk.cas_n),
      .we_n(lk.we_n), .a10(lk.a10), .ba(lk.ba));

   // Clocks; the bench link clock is free running and unrelated in phase
   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   initial
   begin
      lk2.ck = 1'b0;
      #7;
      forever #15 lk2.ck = ~lk2.ck;
   end

   // Cycle count, error pulse counts and the hang limit
   always @(posedge mclk)
   begin
      cyc++;
      if (err === 1'b1)
         n_err1++;
      if (err2 === 1'b1)
         n_err2++;
      if (cyc == 20000)
      begin
         n_fail++;
         tally_and_finish();
      end
   end

   task automatic chk(input string nm, input logic [7:0] got,
      input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic w(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // Request held until the acknowledge is seen, then dropped
   task automatic issue(input ddrbs_cmd_t c, input logic [2:0] b,
      input logic a);
      int k;
      k = 0;
      @(negedge mclk);
      req_cmd = c;
      req_ba = b;
      req_a10 = a;
      req_valid = 1'b1;
      @(negedge mclk);
      while (req_ack !== 1'b1 && k < 400)
      begin
         @(negedge mclk);
         k++;
      end
      req_valid = 1'b0;
      chk("req_ack", {7'h0, req_ack}, 8'h01);
   endtask

   task automatic look(input int b, input logic i, input logic o);
      chk("bank_idle", {7'h0, b_idle[b]}, {7'h0, i});
      chk("bank_open", {7'h0, b_open[b]}, {7'h0, o});
   endtask

   // Bench side link: one command for one link period, NOP around it
   task automatic put2(input logic [3:0] p, input logic [2:0] b);
      @(negedge lk2.ck);
      {lk2.cs_n, lk2.ras_n, lk2.cas_n, lk2.we_n} = p;
      lk2.ba = b;
      @(negedge lk2.ck);
      {lk2.cs_n, lk2.ras_n, lk2.cas_n, lk2.we_n} = 4'h7;
      w(8);
   endtask

   task automatic t_reset_state;
      chk("bank_idle_all", b_idle, 8'hff);
      chk("bank_open_all", b_open, 8'h00);
      chk("dev_busy", {7'h0, busy}, 8'h00);
   endtask

   // Status shows a state from 4 to 4K+3 mclk after the acknowledge
   task automatic t_act_rdap;
      issue(CMD_ACT, 3'h2, 1'b0);
      w(5);
      look(2, 1'b0, 1'b0);
      chk("all_idle_act", {7'h0, a_idle}, 8'h00);
      w(CKM * RCD_CNT);
      look(2, 1'b0, 1'b1);
      issue(CMD_RD, 3'h2, 1'b1);
      w(5);
      look(2, 1'b0, 1'b0);
      w(CKM * (BURST_CNT + RP_CNT));
      look(2, 1'b1, 1'b0);
   endtask

   task automatic t_wrap_pre;
      issue(CMD_ACT, 3'h3, 1'b0);
      issue(CMD_WR, 3'h3, 1'b1);
      w(5);
      look(3, 1'b0, 1'b0);
      w(CKM * (BURST_CNT + RP_CNT));
      look(3, 1'b1, 1'b0);
      issue(CMD_ACT, 3'h1, 1'b0);
      issue(CMD_PRE, 3'h1, 1'b0);
      w(5);
      look(1, 1'b0, 1'b0);
      w(CKM * RP_CNT);
      look(1, 1'b1, 1'b0);
   endtask

   // Busy checked early, just inside and just past the end of the refresh wait; early and past the end of the load mode wait
   task automatic t_ref_lm;
      issue(CMD_REF, 3'h0, 1'b0);
      w(5);
      chk("dev_busy_ref", {7'h0, busy}, 8'h01);
      w(CKM * RFC_CNT - 4);
      chk("dev_busy_ref", {7'h0, busy}, 8'h01);
      w(4);
      chk("dev_busy_ref", {7'h0, busy}, 8'h00);
      chk("all_idle_ref", {7'h0, a_idle}, 8'h01);
      issue(CMD_LM, 3'h0, 1'b0);
      w(5);
      chk("dev_busy_lm", {7'h0, busy}, 8'h01);
      w(CKM * MRD_CNT);
      chk("dev_busy_lm", {7'h0, busy}, 8'h00);
   endtask

   task automatic t_cross_pall;
      issue(CMD_ACT, 3'h6, 1'b0);
      issue(CMD_ACT, 3'h7, 1'b0);
      w(24);
      issue(CMD_RD, 3'h6, 1'b0);
      t0 = cyc;
      issue(CMD_WR, 3'h7, 1'b0);
      chk("wr_gap_ok", {7'h0, (cyc - t0) >= CKM * BURST_CNT},
         8'h01);
      w(5);
      look(7, 1'b0, 1'b0);
      w(CKM * BURST_CNT);
      look(7, 1'b0, 1'b1);
      issue(CMD_PRE, 3'h0, 1'b1);
      w(5);
      chk("dev_busy_pall", {7'h0, busy}, 8'h01);
      chk("bank_idle_pall", b_idle, 8'h00);
      w(CKM * RP_CNT);
      chk("bank_idle_pall", b_idle, 8'hff);
      chk("dev_busy_pall", {7'h0, busy}, 8'h00);
      chk("cmd_error_count", 8'(n_err1), 8'h00);
   endtask

   task automatic t_faults;
      put2(4'h5, 3'h0);
      chk("err_rd_idle", 8'(n_err2), 8'h01);
      put2(4'hb, 3'h0);
      chk("desel_idle", b_idle2, 8'hff);
      put2(4'h7, 3'h0);
      put2(4'h3, 3'h0);
      chk("act_b_idle", b_idle2, 8'hfe);
      put2(4'h1, 3'h0);
      chk("err_ref_open", 8'(n_err2), 8'h02);
      put2(4'h6, 3'h0);
      chk("err_reserved", 8'(n_err2), 8'h03);
      lk2.cke = 1'b0;
      put2(4'h3, 3'h1);
      chk("act_no_cke", b_idle2, 8'hfe);
      chk("err_no_cke", 8'(n_err2), 8'h03);
   endtask

   task automatic tally_and_finish;
      $display("Counts: %0d compares, %0d mismatches", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      {n_fail, cmp_count, n_err1, n_err2, cyc, t0} = '0;
      {resetn, req_valid, req_a10, lk2.cke, lk2.a10} = '0;
      req_cmd = CMD_NOP;
      req_ba = 3'h0;
      lk2.ba = 3'h0;
      {lk2.cs_n, lk2.ras_n, lk2.cas_n, lk2.we_n} = 4'h7;
      repeat (12) @(negedge mclk);
      resetn = 1'b1;
      lk2.cke = 1'b1;
      w(40);
      t_reset_state();
      t_act_rdap();
      t_wrap_pre();
      t_ref_lm();
      t_cross_pall();
      t_faults();
      tally_and_finish();
   end
endmodule
`default_nettype wire
